// ### verilog/rscl_pkg.sv
package rscl_pkg;

  localparam int AXI_ADDR_W  = 12;
  localparam int AXI_DATA_W  = 32;
  localparam int MGMT_ADDR_W = 5;
  localparam int CAP_W       = 2;
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic [MGMT_ADDR_W-1:0] addr;
    logic                   sw_sel;
    logic                   autoneg_enable_strap;
    logic [CAP_W-1:0]       cap;
  } rscl_strap_s;

  localparam int STRAP_W = $bits(rscl_strap_s);

  // levels that the internal pad pulls give when no strap resistor is fitted
  localparam logic [MGMT_ADDR_W-1:0] ADDR_DEFAULT  = 5'h01;
  localparam logic                   SWSEL_DEFAULT = 1'h1;
  localparam logic                   AN_DEFAULT    = 1'h1;
  localparam logic [CAP_W-1:0]       CAP_DEFAULT   = 2'h3;
  localparam rscl_strap_s STRAP_DEFAULT = '{
    addr: ADDR_DEFAULT, sw_sel: SWSEL_DEFAULT, autoneg_enable_strap: AN_DEFAULT, cap: CAP_DEFAULT};

  typedef enum logic [1:0] {
    MODE_10_HALF  = 2'b00,
    MODE_10_FULL  = 2'b01,
    MODE_100_HALF = 2'b10,
    MODE_100_FULL = 2'b11
  } rscl_mode_e;

  typedef enum logic [1:0] {
    ST_STRAPPING = 2'b00,
    ST_SW_HOLD   = 2'b01,
    ST_RUN       = 2'b10
  } rscl_state_e;

  localparam logic [AXI_ADDR_W-1:0] REG_BMCR    = 12'h000;
  localparam logic [AXI_ADDR_W-1:0] REG_STRAP   = 12'h004;
  localparam logic [AXI_ADDR_W-1:0] REG_SWCFG   = 12'h008;
  localparam logic [AXI_ADDR_W-1:0] REG_RELEASE = 12'h00c;
  localparam logic [AXI_ADDR_W-1:0] REG_ADVERT  = 12'h010;

  localparam int BMCR_DUPLEX_BIT = 8;
  localparam int BMCR_PDOWN_BIT  = 11;
  localparam int BMCR_AN_BIT     = 12;
  localparam int BMCR_SPEED_BIT  = 13;

  localparam int SWCFG_ADDR_LSB = 0;
  localparam int SWCFG_AN_BIT   = 8;
  localparam int SWCFG_CAP_LSB  = 9;

  localparam int STAT_ADDR_LSB  = 0;
  localparam int STAT_SWSEL_BIT = 5;
  localparam int STAT_AN_BIT    = 6;
  localparam int STAT_CAP_LSB   = 7;
  localparam int STAT_HOLD_BIT  = 9;

  localparam int LANE_LOW  = 0;
  localparam int LANE_HIGH = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### verilog/rscl_strap_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module rscl_strap_sampler #(
  parameter int                W       = 9,
  parameter logic [W-1:0]      DEFAULT = '0
) (
  input  wire  logic         aclk,
  input  wire  logic         aresetn,
  input  wire  logic [W-1:0] pin_in,
  output logic       [W-1:0] value
);

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [rscl_pkg::SYNC_STAGES-1:0] fill;

  // synchroniser runs free so that it keeps sampling while reset is held
  always_ff @(posedge aclk) begin
    sync1 <= pin_in;
    sync2 <= sync1;
  end

  // until both stages hold a real sample the pad default stands in
  // ones shift in, so the power-up reset fills without a known start value
  always_ff @(posedge aclk) begin
    if (aresetn) begin
      fill <= '0;
    end else begin
      fill <= {fill[rscl_pkg::SYNC_STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value <= (&fill) ? sync2 : DEFAULT;
    end
  end

endmodule

`default_nettype wire

// ### verilog/rscl_reset_strap_config_latch.sv
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module rscl_reset_strap_config_latch (
  input  wire  logic                                aclk,
  input  wire  logic                                aresetn,
  input  wire  logic [rscl_pkg::AXI_ADDR_W-1:0]     s_axi_awaddr,
  input  wire  logic [2:0]                          s_axi_awprot,
  input  wire  logic                                s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire  logic [rscl_pkg::AXI_DATA_W-1:0]     s_axi_wdata,
  input  wire  logic [3:0]                          s_axi_wstrb,
  input  wire  logic                                s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire  logic                                s_axi_bready,
  input  wire  logic [rscl_pkg::AXI_ADDR_W-1:0]     s_axi_araddr,
  input  wire  logic [2:0]                          s_axi_arprot,
  input  wire  logic                                s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [rscl_pkg::AXI_DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire  logic                                s_axi_rready,
  input  wire  logic [rscl_pkg::MGMT_ADDR_W-1:0]    mgmt_address_strap_in,
  output logic       [rscl_pkg::MGMT_ADDR_W-1:0]    mgmt_address_strap_out,
  output logic       [rscl_pkg::MGMT_ADDR_W-1:0]    mgmt_address_strap_oe,
  input  wire  logic                                software_strap_select,
  input  wire  logic                                autoneg_enable_strap_in,
  output logic                                      autoneg_enable_strap_out,
  output logic                                      autoneg_enable_strap_oe,
  input  wire  logic                                capability_strap_bit1_in,
  output logic                                      capability_strap_bit1_out,
  output logic                                      capability_strap_bit1_oe,
  input  wire  logic                                capability_strap_bit0_in,
  output logic                                      capability_strap_bit0_out,
  output logic                                      capability_strap_bit0_oe,
  input  wire  logic                                func_col,
  input  wire  logic [3:0]                          func_rxd,
  input  wire  logic [2:0]                          func_led,
  output logic       [rscl_pkg::MGMT_ADDR_W-1:0]    mgmt_address,
  output logic                                      power_down,
  output logic                                      autoneg_run,
  output logic                                      link_speed_100,
  output logic                                      link_full_duplex,
  output logic       [3:0]                          advertise
);

  ////////////////////////////////////////////////////////////////////////////
  // strap capture

  rscl_pkg::rscl_strap_s  strap_pins;
  rscl_pkg::rscl_strap_s  strap_latched;
  rscl_pkg::rscl_strap_s  active;
  rscl_pkg::rscl_strap_s  swcfg;
  rscl_pkg::rscl_state_e  state;

  // bit order of the struct: addr, sw_sel, autoneg_enable_strap, cap
  assign strap_pins = '{
    addr:   mgmt_address_strap_in,
    sw_sel: software_strap_select,
    autoneg_enable_strap:  autoneg_enable_strap_in,
    cap:    {capability_strap_bit1_in, capability_strap_bit0_in}};

  rscl_strap_sampler #(
    .W       (rscl_pkg::STRAP_W),
    .DEFAULT (rscl_pkg::STRAP_DEFAULT)
  ) u_sampler (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (strap_pins),
    .value   (strap_latched)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  logic                               aw_held;
  logic                               w_held;
  logic [rscl_pkg::AXI_ADDR_W-1:0]    wr_addr;
  logic [rscl_pkg::AXI_DATA_W-1:0]    wr_data;
  logic [3:0]                         wr_strb;
  logic                               do_write;
  logic                               ar_take;
  logic                               release_hit;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  function automatic logic [rscl_pkg::AXI_ADDR_W-1:0] word_of(
    input logic [rscl_pkg::AXI_ADDR_W-1:0] a);
    word_of = {a[rscl_pkg::AXI_ADDR_W-1:2], 2'h0};
  endfunction

  function automatic logic mapped(input logic [rscl_pkg::AXI_ADDR_W-1:0] a);
    logic [rscl_pkg::AXI_ADDR_W-1:0] w;
    w = word_of(a);
    mapped = (w == rscl_pkg::REG_BMCR) || (w == rscl_pkg::REG_STRAP) ||
             (w == rscl_pkg::REG_SWCFG) || (w == rscl_pkg::REG_RELEASE) ||
             (w == rscl_pkg::REG_ADVERT);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      wr_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wr_data <= '0;
      wr_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      wr_data <= s_axi_wdata;
      wr_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rscl_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wr_addr) ? rscl_pkg::RESP_OKAY : rscl_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // a read of the release word counts as an access too
  assign release_hit = (do_write && word_of(wr_addr) == rscl_pkg::REG_RELEASE) ||
                       (ar_take && word_of(s_axi_araddr) == rscl_pkg::REG_RELEASE);

  ////////////////////////////////////////////////////////////////////////////
  // strapping state

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= rscl_pkg::ST_STRAPPING;
    end else begin
      unique case (state)
        rscl_pkg::ST_STRAPPING: begin
          if (!strap_latched.sw_sel) begin
            state <= rscl_pkg::ST_SW_HOLD;
          end else begin
            state <= rscl_pkg::ST_RUN;
          end
        end
        rscl_pkg::ST_SW_HOLD: begin
          if (release_hit) begin
            state <= rscl_pkg::ST_RUN;
          end
        end
        rscl_pkg::ST_RUN: begin
          state <= rscl_pkg::ST_RUN;
        end
        default: begin
          state <= rscl_pkg::ST_STRAPPING;
        end
      endcase
    end
  end

  // every 5-bit code is a legal address, no check applies
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active <= rscl_pkg::STRAP_DEFAULT;
    end else if (state == rscl_pkg::ST_STRAPPING) begin
      active <= strap_latched;
    end else if (state == rscl_pkg::ST_SW_HOLD && release_hit) begin
      active <= swcfg;
    end
  end

  // writes only land while held in software strapping power-down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      swcfg <= rscl_pkg::STRAP_DEFAULT;
    end else if (state == rscl_pkg::ST_STRAPPING) begin
      swcfg <= strap_latched;
    end else if (state == rscl_pkg::ST_SW_HOLD && do_write &&
                 word_of(wr_addr) == rscl_pkg::REG_SWCFG) begin
      if (wr_strb[rscl_pkg::LANE_LOW]) begin
        swcfg.addr <= wr_data[rscl_pkg::SWCFG_ADDR_LSB +: rscl_pkg::MGMT_ADDR_W];
      end
      if (wr_strb[rscl_pkg::LANE_HIGH]) begin
        swcfg.autoneg_enable_strap <= wr_data[rscl_pkg::SWCFG_AN_BIT];
        swcfg.cap   <= wr_data[rscl_pkg::SWCFG_CAP_LSB +: rscl_pkg::CAP_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // basic mode control

  logic bmcr_an;
  logic bmcr_speed;
  logic bmcr_duplex;
  logic bmcr_pdown;
  logic bmcr_wr;

  assign bmcr_wr = do_write && word_of(wr_addr) == rscl_pkg::REG_BMCR &&
                   state != rscl_pkg::ST_STRAPPING && wr_strb[rscl_pkg::LANE_HIGH];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bmcr_an     <= 1'b0;
      bmcr_speed  <= 1'b0;
      bmcr_duplex <= 1'b0;
      bmcr_pdown  <= 1'b0;
    end else if (state == rscl_pkg::ST_STRAPPING) begin
      bmcr_an     <= strap_latched.autoneg_enable_strap;
      bmcr_speed  <= strap_latched.cap[1];
      bmcr_duplex <= strap_latched.cap[0];
      bmcr_pdown  <= 1'b0;
    end else if (state == rscl_pkg::ST_SW_HOLD && release_hit) begin
      bmcr_an     <= swcfg.autoneg_enable_strap;
      bmcr_speed  <= swcfg.cap[1];
      bmcr_duplex <= swcfg.cap[0];
    end else if (bmcr_wr) begin
      bmcr_an     <= wr_data[rscl_pkg::BMCR_AN_BIT];
      bmcr_speed  <= wr_data[rscl_pkg::BMCR_SPEED_BIT];
      bmcr_duplex <= wr_data[rscl_pkg::BMCR_DUPLEX_BIT];
      bmcr_pdown  <= wr_data[rscl_pkg::BMCR_PDOWN_BIT];
    end
  end

  function automatic logic [3:0] adv_of(input logic an, input logic [1:0] cap);
    rscl_pkg::rscl_mode_e m;
    m = rscl_pkg::rscl_mode_e'(cap);
    adv_of = 4'h0;
    if (an) begin
      adv_of[m] = 1'b1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // outputs and pads

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mgmt_address     <= rscl_pkg::ADDR_DEFAULT;
      power_down       <= 1'b0;
      autoneg_run      <= 1'b0;
      link_speed_100   <= 1'b0;
      link_full_duplex <= 1'b0;
      advertise        <= 4'h0;
    end else begin
      mgmt_address     <= active.addr;
      power_down       <= (state == rscl_pkg::ST_SW_HOLD) || bmcr_pdown;
      autoneg_run      <= bmcr_an && state == rscl_pkg::ST_RUN;
      link_speed_100   <= bmcr_speed;
      link_full_duplex <= bmcr_duplex;
      advertise        <= adv_of(bmcr_an, {bmcr_speed, bmcr_duplex});
    end
  end

  // pads stay released while straps are read, so the board resistors win
  logic pads_on;

  assign pads_on = state != rscl_pkg::ST_STRAPPING;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mgmt_address_strap_out    <= '0;
      autoneg_enable_strap_out  <= 1'b0;
      capability_strap_bit1_out <= 1'b0;
      capability_strap_bit0_out <= 1'b0;
    end else begin
      mgmt_address_strap_out    <= {func_rxd, func_col};
      autoneg_enable_strap_out  <= func_led[2];
      capability_strap_bit1_out <= func_led[1];
      capability_strap_bit0_out <= func_led[0];
    end
  end

  assign mgmt_address_strap_oe    = {rscl_pkg::MGMT_ADDR_W{pads_on}};
  assign autoneg_enable_strap_oe  = pads_on;
  assign capability_strap_bit1_oe = pads_on;
  assign capability_strap_bit0_oe = pads_on;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic [rscl_pkg::AXI_DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = '0;
    unique case (word_of(s_axi_araddr))
      rscl_pkg::REG_BMCR: begin
        rd_word[rscl_pkg::BMCR_AN_BIT]     = bmcr_an;
        rd_word[rscl_pkg::BMCR_SPEED_BIT]  = bmcr_speed;
        rd_word[rscl_pkg::BMCR_DUPLEX_BIT] = bmcr_duplex;
        rd_word[rscl_pkg::BMCR_PDOWN_BIT]  = power_down;
      end
      rscl_pkg::REG_STRAP: begin
        rd_word[rscl_pkg::STAT_ADDR_LSB +: rscl_pkg::MGMT_ADDR_W] = strap_latched.addr;
        rd_word[rscl_pkg::STAT_SWSEL_BIT] = strap_latched.sw_sel;
        rd_word[rscl_pkg::STAT_AN_BIT]    = strap_latched.autoneg_enable_strap;
        rd_word[rscl_pkg::STAT_CAP_LSB +: rscl_pkg::CAP_W] = strap_latched.cap;
        rd_word[rscl_pkg::STAT_HOLD_BIT]  = state == rscl_pkg::ST_SW_HOLD;
      end
      rscl_pkg::REG_SWCFG: begin
        rd_word[rscl_pkg::SWCFG_ADDR_LSB +: rscl_pkg::MGMT_ADDR_W] = swcfg.addr;
        rd_word[rscl_pkg::SWCFG_AN_BIT] = swcfg.autoneg_enable_strap;
        rd_word[rscl_pkg::SWCFG_CAP_LSB +: rscl_pkg::CAP_W] = swcfg.cap;
      end
      rscl_pkg::REG_ADVERT: begin
        rd_word[3:0] = advertise;
      end
      default: begin
        rd_word = '0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= rscl_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= mapped(s_axi_araddr) ? rscl_pkg::RESP_OKAY : rscl_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### bench/rscl_reset_strap_config_latch_properties.sv
`timescale 1ns/1ps
`default_nettype none

module rscl_config_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [4:0]  mgmt_address_strap_in,
  input wire logic [4:0]  mgmt_address_strap_out,
  input wire logic [4:0]  mgmt_address_strap_oe,
  input wire logic        software_strap_select,
  input wire logic        autoneg_enable_strap_in,
  input wire logic        autoneg_enable_strap_out,
  input wire logic        autoneg_enable_strap_oe,
  input wire logic        capability_strap_bit1_in,
  input wire logic        capability_strap_bit0_in,
  input wire logic        func_col,
  input wire logic [3:0]  func_rxd,
  input wire logic [2:0]  func_led,
  input wire logic [4:0]  mgmt_address,
  input wire logic        power_down,
  input wire logic        autoneg_run,
  input wire logic        link_speed_100,
  input wire logic        link_full_duplex,
  input wire logic [3:0]  advertise
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // depth 5 reaches back into reset, so the bench must hold straps the whole reset
  a_pads_released: assert property ($rose(aresetn) |-> mgmt_address_strap_oe == 5'h00
    && !autoneg_enable_strap_oe) else $error("strap pad driven during reset");
  a_pads_driven: assert property ($rose(aresetn) |=> mgmt_address_strap_oe == 5'h1f
    && autoneg_enable_strap_oe) else $error("strap pad not driven after reset");
  a_addr_func: assert property ((&mgmt_address_strap_oe) && $past(&mgmt_address_strap_oe)
    |-> mgmt_address_strap_out == $past({func_rxd, func_col})) else $error("address pad wrong");
  a_led_func: assert property (autoneg_enable_strap_oe && $past(autoneg_enable_strap_oe)
    |-> autoneg_enable_strap_out == $past(func_led[2])) else $error("mode pad wrong");
  a_addr_latch: assert property ($rose(aresetn) |-> ##2
    mgmt_address == $past(mgmt_address_strap_in, 5)) else $error("address not latched");
  a_sw_hold: assert property ($rose(aresetn) |-> ##2
    power_down == !$past(software_strap_select, 5)) else $error("power down wrong");
  a_an_mode: assert property ($rose(aresetn) |-> ##2 autoneg_run ==
    ($past(autoneg_enable_strap_in, 5) && $past(software_strap_select, 5)))
    else $error("negotiation state wrong");
  a_cap_mode: assert property ($rose(aresetn) |-> ##2
    {link_speed_100, link_full_duplex} ==
    {$past(capability_strap_bit1_in, 5), $past(capability_strap_bit0_in, 5)})
    else $error("speed or duplex wrong");
  a_advert_sel: assert property (autoneg_run |->
    advertise == 4'h1 << {link_speed_100, link_full_duplex}) else $error("advertise wrong");
  a_release_wake: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h00c
    |-> ##[1:3] !power_down) else $error("release did not wake");

  c_sw_hold: cover property ($rose(aresetn) && !software_strap_select);
  c_forced: cover property ($rose(aresetn) && !autoneg_enable_strap_in);
  c_release: cover property (s_axi_arvalid && s_axi_arready && power_down);
endmodule

bind rscl_reset_strap_config_latch rscl_config_checker i_rscl_config_checker (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .mgmt_address_strap_in,
  .mgmt_address_strap_out, .mgmt_address_strap_oe, .software_strap_select,
  .autoneg_enable_strap_in, .autoneg_enable_strap_out, .autoneg_enable_strap_oe,
  .capability_strap_bit1_in, .capability_strap_bit0_in, .func_col, .func_rxd, .func_led,
  .mgmt_address, .power_down, .autoneg_run, .link_speed_100, .link_full_duplex, .advertise);
`default_nettype wire

// ### bench/rscl_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

// pads ordered {an, cap1, cap0, addr4..0}
module rscl_strap_board (
  input  wire logic [7:0] fit,
  input  wire logic [7:0] lvl,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] drv,
  output wire logic [7:0] pad
);
  // unfitted pad settles to its internal pull: mode straps and addr0 up, addr4:1 down
  localparam logic [7:0] PULL = 8'he1;
  // resistor stays fitted after reset, a driving device overrides it
  assign pad = (oe & drv) | (~oe & ((fit & lvl) | (~fit & PULL)));
endmodule
`default_nettype wire

// ### bench/rscl_reset_strap_config_latch_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module rscl_reset_strap_config_latch_tb_top;
  // {fit, sw, an, cap[1:0], addr[4:0]}; first entry has no resistors fitted
  localparam logic [9:0] CFG [5] = '{10'h100, 10'h300, 10'h33f, 10'h3ca, 10'h275};
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic        software_strap_select, func_col, sw, ean;
  logic [3:0]  func_rxd, advertise;
  logic [2:0]  func_led;
  wire  logic [2:0] mode_out, mode_oe;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, ecap;
  logic [4:0]  mgmt_address, addr_out, addr_oe, ea;
  logic        power_down, autoneg_run, link_speed_100, link_full_duplex;
  logic [7:0]  fit, lvl;
  logic [9:0]  c;
  wire  logic [7:0] pad;
  int          failures, compares;

  rscl_reset_strap_config_latch i_rscl_reset_strap_config_latch (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready(1'h1), .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'h1),
    .mgmt_address_strap_in(pad[4:0]), .mgmt_address_strap_out(addr_out),
    .mgmt_address_strap_oe(addr_oe), .software_strap_select,
    .autoneg_enable_strap_in(pad[7]), .autoneg_enable_strap_out(mode_out[2]),
    .autoneg_enable_strap_oe(mode_oe[2]), .capability_strap_bit1_in(pad[6]),
    .capability_strap_bit1_out(mode_out[1]), .capability_strap_bit1_oe(mode_oe[1]),
    .capability_strap_bit0_in(pad[5]), .capability_strap_bit0_out(mode_out[0]),
    .capability_strap_bit0_oe(mode_oe[0]), .func_col, .func_rxd, .func_led, .mgmt_address,
    .power_down, .autoneg_run, .link_speed_100, .link_full_duplex, .advertise);

  rscl_strap_board i_rscl_strap_board (.fit(fit), .lvl(lvl), .oe({mode_oe, addr_oe}),
    .drv({mode_out, addr_out}), .pad(pad));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ready is sampled at the negedge so the drop after the edge never races it
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic aw, w, hs_aw, hs_w;
    int   n;
    aw = 1'h1;
    w = 1'h1;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      hs_aw = aw & s_axi_awready;
      hs_w = w & s_axi_wready;
      rs = s_axi_bresp;
      if (!aw && !w && s_axi_bvalid === 1'h1) break;
      @(posedge aclk);
      if (hs_aw) begin
        s_axi_awvalid <= 1'h0;
        aw = 1'h0;
      end
      if (hs_w) begin
        s_axi_wvalid <= 1'h0;
        w = 1'h0;
      end
    end
    if (n == 40) begin
      failures++;
      close_out();
    end
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic ar, hs;
    int   n;
    ar = 1'h1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge aclk);
      hs = ar & s_axi_arready;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      if (!ar && s_axi_rvalid === 1'h1) break;
      @(posedge aclk);
      if (hs) begin
        s_axi_arvalid <= 1'h0;
        ar = 1'h0;
      end
    end
    if (n == 40) begin
      failures++;
      close_out();
    end
    @(posedge aclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'h0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    failures = 0;
    compares = 0;
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {software_strap_select, func_col, func_rxd, func_led, fit, lvl} = '0;
    for (int i = 0; i < 5; i++) begin
      c = CFG[i];
      @(posedge aclk);
      aresetn <= 1'h0;
      fit <= {8{c[9]}};
      lvl <= c[7:0];
      software_strap_select <= c[8];
      func_rxd <= 4'(i + 3);
      func_col <= i[0];
      func_led <= 3'(i + 5);
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      sw = c[8];
      ea = c[9] ? c[4:0] : 5'h01;
      ean = c[9] ? c[7] : 1'h1;
      ecap = c[9] ? c[6:5] : 2'h3;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk({mgmt_address, power_down, autoneg_run}, {ea, ~sw, ean & sw});
      chk({link_speed_100, link_full_duplex, advertise},
          {ecap, (ean & sw) ? 4'h1 << ecap : 4'h0});
      chk({pad, addr_oe}, {func_led, func_rxd, func_col, 5'h1f});
      @(posedge aclk);
      axi_rd(rscl_pkg::REG_BMCR, d, r);
      chk({d[13], d[12], d[8]}, {ecap[1], ean, ecap[0]});
      axi_rd(rscl_pkg::REG_STRAP, d, r);
      chk(d[9:0], {~sw, ecap, ean, sw, ea});
      if (!sw) begin
        axi_wr(rscl_pkg::REG_SWCFG, 32'h00000507, r);
        chk(r, rscl_pkg::RESP_OKAY);
        axi_rd(rscl_pkg::REG_RELEASE, d, r);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk({power_down, autoneg_run, link_speed_100, link_full_duplex, advertise, mgmt_address},
            {4'h6, 4'h4, 5'h07});
        @(posedge aclk);
      end else begin
        // writes outside the hold are accepted but must not reach the config
        axi_wr(rscl_pkg::REG_SWCFG, 32'h000007ff, r);
        axi_rd(rscl_pkg::REG_SWCFG, d, r);
        chk({d[10:8], d[4:0], mgmt_address}, {ecap, ean, ea, ea});
      end
      $display("test %0d done", i);
    end
    axi_wr(12'h020, 32'h00000001, r);
    chk(r, rscl_pkg::RESP_SLVERR);
    axi_rd(12'h020, d, r);
    chk(d, 32'h0);
    chk(r, rscl_pkg::RESP_SLVERR);
    $display("test unmapped done");
    close_out();
  end
endmodule
`default_nettype wire
